// >>> verilog/tic_pkg.sv
// Package for the 16-bit interval timer core: register map, fields, modes.
// Assumes a single mclk domain and the plain strobe register port.
package tic_pkg;
  // Register word indices
  localparam logic [2:0] OFF_CTL0 = 3'h0;
  localparam logic [2:0] OFF_CTL1 = 3'h1;
  localparam logic [2:0] OFF_IOC1 = 3'h2;
  localparam logic [2:0] OFF_IOC2 = 3'h3;
  localparam logic [2:0] OFF_OPT0 = 3'h4;
  localparam logic [2:0] OFF_CCR0 = 3'h5;
  localparam logic [2:0] OFF_CCR1 = 3'h6;
  localparam logic [2:0] OFF_CNT = 3'h7;
  // Field positions
  localparam int CTL0_CE = 7;
  localparam int CTL0_PRS_LO = 0;
  localparam int CTL1_EST = 6;
  localparam int CTL1_EEE = 5;
  localparam int CTL1_MD_LO = 0;
  localparam int EDGE_HI = 1;
  localparam int EDGE_LO = 0;
  localparam int OPT0_OVF = 0;
  localparam int OPT0_CCS0 = 1;
  // Values
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] DIV_FULL = 8'hff;
  localparam logic [7:0] DIV_ZERO = 8'h00;

  typedef enum logic [2:0] {
    MD_INTERVAL = 3'b000,
    MD_EVENT = 3'b001,
    MD_EXTTRIG = 3'b010,
    MD_ONESHOT = 3'b011,
    MD_PWM = 3'b100,
    MD_FREERUN = 3'b101,
    MD_PWIDTH = 3'b110,
    MD_RSVD = 3'b111
  } tic_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tic_bus_t;
endpackage

// >>> verilog/tic_edge_sync.sv
// Pin synchroniser with selectable edge detection.
// Assumes pin_in is asynchronous to mclk; edge_sel 00 none, 01 rise, 10 fall, 11 both.
`timescale 1ns/100ps
module tic_edge_sync
  import tic_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);
  logic sync1;
  logic sync2;
  logic prev;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  always_comb
  begin
    edge_pulse = (edge_sel[0] & sync2 & ~prev) | (edge_sel[1] & ~sync2 & prev);
  end
endmodule // tic_edge_sync

// >>> verilog/timer16_interval_core.sv
// 16-bit timer core: counting, read-back, compare transfer, interval mode.
// Assumes a register master on mclk and an asynchronous external input pin.
`timescale 1ns/100ps
module timer16_interval_core
  import tic_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire tic_bus_t bus,
  output logic [15:0] rdata,
  input wire logic ext_input0_pin,
  output logic timer_output0_pin,
  output logic timer_output1_pin,
  output logic compare0_irq,
  output logic compare1_irq,
  output logic overflow_irq
);
  logic count_enable_bit;
  logic [2:0] prescale_sel;
  tic_mode_t mode_select_field;
  logic ext_clock_select_bit;
  logic input_edge_sel_hi;
  logic input_edge_sel_lo;
  logic event_edge_sel_hi;
  logic event_edge_sel_lo;
  logic overflow_flag;
  logic capture_sel0;
  logic [15:0] compare_reg0;
  logic [15:0] compare_reg1;
  logic [15:0] compare_buffer0;
  logic [15:0] compare_buffer1;
  logic batch_pending;
  logic [15:0] count;
  logic first_tick;
  logic ovf_hold;
  logic [7:0] div;
  logic evt_edge;
  logic cap_edge;
  logic pre_tick;
  logic tick;
  logic match0;
  logic match1;
  logic clr_hit;
  logic wrap;
  logic ovf_ev;
  logic cap_ev;
  logic trig;
  logic batch_xfer;
  logic wr_ctl1;

  ////////////////////////////////////////////////////////////////////////////
  // Mode properties

  function automatic logic is_batch(input tic_mode_t m);
    is_batch = (m == MD_EXTTRIG) || (m == MD_PWM);
  endfunction

  function automatic logic clears_on_match(input tic_mode_t m);
    clears_on_match = (m != MD_FREERUN) && (m != MD_PWIDTH);
  endfunction

  function automatic logic has_ovf(input tic_mode_t m);
    has_ovf = (m == MD_FREERUN) || (m == MD_PWIDTH);
  endfunction

  function automatic logic wr_hit(input tic_bus_t b, input logic [2:0] off);
    wr_hit = b.wr && (b.addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Count clock and events

  tic_edge_sync u_evt_edge (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in(ext_input0_pin),
    .edge_sel({event_edge_sel_hi, event_edge_sel_lo}),
    .edge_pulse(evt_edge)
  );

  tic_edge_sync u_cap_edge (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in(ext_input0_pin),
    .edge_sel({input_edge_sel_hi, input_edge_sel_lo}),
    .edge_pulse(cap_edge)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      div <= DIV_ZERO;
    else if (!count_enable_bit)
      div <= DIV_ZERO;
    else
      div <= div + 8'h01;
  end

  always_comb
  begin
    pre_tick = (div & ~(DIV_FULL << prescale_sel)) == ~(DIV_FULL << prescale_sel);
    if (mode_select_field == MD_EVENT || ext_clock_select_bit)
      tick = count_enable_bit & evt_edge;
    else
      tick = count_enable_bit & pre_tick;
    match0 = (count == compare_buffer0);
    match1 = (count == compare_buffer1);
    clr_hit = match0 && clears_on_match(mode_select_field);
    wrap = tick && !first_tick && !clr_hit && (count == ALL_ONES);
    ovf_ev = wrap && has_ovf(mode_select_field) && !ovf_hold
      && !(compare_buffer0 == ALL_ONES && mode_select_field == MD_FREERUN && !capture_sel0);
    cap_ev = count_enable_bit && cap_edge && (mode_select_field == MD_PWIDTH
      || (mode_select_field == MD_FREERUN && capture_sel0));
    wr_ctl1 = wr_hit(bus, OFF_CTL1);
    trig = count_enable_bit && (wr_ctl1 && bus.wdata[CTL1_EST] || cap_edge)
      && (mode_select_field == MD_EXTTRIG || mode_select_field == MD_ONESHOT);
    batch_xfer = tick && !first_tick && match0 && batch_pending
      && is_batch(mode_select_field);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= ALL_ONES;
      first_tick <= 1'b1;
      ovf_hold <= 1'b0;
    end
    else if (!count_enable_bit)
    begin
      count <= ALL_ONES;
      first_tick <= 1'b1;
      ovf_hold <= 1'b0;
    end
    else if (cap_ev && mode_select_field == MD_PWIDTH)
    begin
      count <= ZERO16;
      ovf_hold <= (count == ALL_ONES);
    end
    else if (trig)
    begin
      count <= ZERO16;
      first_tick <= 1'b0;
    end
    else if (tick)
    begin
      first_tick <= 1'b0;
      if (first_tick || clr_hit)
        count <= ZERO16;
      else
        count <= count + 16'h0001;
      if (wrap)
        ovf_hold <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses and outputs

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      compare0_irq <= 1'b0;
      compare1_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      // Start wrap never reaches the compare path
      compare0_irq <= tick && !first_tick && match0
        && mode_select_field != MD_PWIDTH;
      compare1_irq <= tick && !first_tick && match1
        && mode_select_field != MD_PWIDTH;
      overflow_irq <= ovf_ev;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_output0_pin <= 1'b0;
      timer_output1_pin <= 1'b0;
    end
    else if (!count_enable_bit)
    begin
      timer_output0_pin <= 1'b0;
      timer_output1_pin <= 1'b0;
    end
    else if (tick && mode_select_field == MD_INTERVAL)
    begin
      if (first_tick || match0)
        timer_output0_pin <= ~timer_output0_pin;
      if (!first_tick && match1)
        timer_output1_pin <= ~timer_output1_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare buffers

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      compare_buffer0 <= ZERO16;
      compare_buffer1 <= ZERO16;
      batch_pending <= 1'b0;
    end
    else if (!count_enable_bit)
    begin
      compare_buffer0 <= ZERO16;
      compare_buffer1 <= ZERO16;
      batch_pending <= 1'b0;
    end
    else
    begin
      if ((tick && first_tick) || batch_xfer)
      begin
        compare_buffer0 <= compare_reg0;
        compare_buffer1 <= compare_reg1;
      end
      if (!is_batch(mode_select_field))
      begin
        if (wr_hit(bus, OFF_CCR0))
          compare_buffer0 <= bus.wdata;
        if (wr_hit(bus, OFF_CCR1))
          compare_buffer1 <= bus.wdata;
      end
      if (wr_hit(bus, OFF_CCR1) && is_batch(mode_select_field))
        batch_pending <= 1'b1;
      else if (batch_xfer)
        batch_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_enable_bit <= 1'b0;
      prescale_sel <= 3'h0;
      mode_select_field <= MD_INTERVAL;
      ext_clock_select_bit <= 1'b0;
      input_edge_sel_hi <= 1'b0;
      input_edge_sel_lo <= 1'b0;
      event_edge_sel_hi <= 1'b0;
      event_edge_sel_lo <= 1'b0;
      capture_sel0 <= 1'b0;
      compare_reg0 <= ZERO16;
      compare_reg1 <= ZERO16;
    end
    else
    begin
      if (wr_hit(bus, OFF_CTL0))
      begin
        count_enable_bit <= bus.wdata[CTL0_CE];
        prescale_sel <= bus.wdata[CTL0_PRS_LO +: 3];
      end
      if (wr_ctl1)
      begin
        mode_select_field <= tic_mode_t'(bus.wdata[CTL1_MD_LO +: 3]);
        ext_clock_select_bit <= bus.wdata[CTL1_EEE];
      end
      if (wr_hit(bus, OFF_IOC1))
      begin
        input_edge_sel_hi <= bus.wdata[EDGE_HI];
        input_edge_sel_lo <= bus.wdata[EDGE_LO];
      end
      if (wr_hit(bus, OFF_IOC2))
      begin
        event_edge_sel_hi <= bus.wdata[EDGE_HI];
        event_edge_sel_lo <= bus.wdata[EDGE_LO];
      end
      if (wr_hit(bus, OFF_OPT0))
        capture_sel0 <= bus.wdata[OPT0_CCS0];
      if (cap_ev)
        compare_reg0 <= count;
      else if (wr_hit(bus, OFF_CCR0))
        compare_reg0 <= bus.wdata;
      if (wr_hit(bus, OFF_CCR1))
        compare_reg1 <= bus.wdata;
    end
  end

  // Overflow flag: a new overflow beats a software clear
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      overflow_flag <= 1'b0;
    else if (ovf_ev)
      overflow_flag <= 1'b1;
    else if (wr_hit(bus, OFF_OPT0) && !bus.wdata[OPT0_OVF])
      overflow_flag <= 1'b0;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= ZERO16;
    else if (!bus.rd)
      rdata <= ZERO16;
    else
    begin
      case (bus.addr)
        OFF_CTL0: rdata <= {8'h00, count_enable_bit, 4'h0, prescale_sel};
        OFF_CTL1: rdata <= {10'h000, ext_clock_select_bit, 2'b00, mode_select_field};
        OFF_IOC1: rdata <= {14'h0000, input_edge_sel_hi, input_edge_sel_lo};
        OFF_IOC2: rdata <= {14'h0000, event_edge_sel_hi, event_edge_sel_lo};
        OFF_OPT0: rdata <= {14'h0000, capture_sel0, overflow_flag};
        OFF_CCR0: rdata <= compare_reg0;
        OFF_CCR1: rdata <= compare_reg1;
        OFF_CNT: rdata <= count_enable_bit ? count : ZERO16;
        default: rdata <= ZERO16;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_start;
    tick && first_tick && !trig && !cap_ev && mode_select_field == MD_INTERVAL;
  endsequence

  sequence s_match0;
    tick && !first_tick && !trig && !cap_ev && match0
      && mode_select_field == MD_INTERVAL;
  endsequence

  cnt_read_a: assert property (bus.rd && bus.addr == OFF_CNT && !count_enable_bit
    |=> rdata == ZERO16 && count == ALL_ONES)
    else $error("disabled counter read not zero");

  start_clear_a: assert property (s_start
    |=> count == ZERO16 && timer_output0_pin != $past(timer_output0_pin)
      && !compare0_irq && !compare1_irq)
    else $error("start step wrong");

  match_clear_a: assert property (s_match0
    |=> compare0_irq && count == ZERO16 && timer_output0_pin != $past(timer_output0_pin))
    else $error("match0 did not clear and toggle");

  irq_cause_a: assert property ($rose(compare0_irq)
    |-> $past(tick) && !$past(first_tick) && $past(match0))
    else $error("irq0 without a match");

  ovf_set_a: assert property (ovf_ev && count_enable_bit
    |=> overflow_flag && overflow_irq ##1 overflow_flag)
    else $error("overflow not flagged");

  batch_xfer_a: assert property (batch_xfer && !wr_hit(bus, OFF_CCR0)
    |=> compare_buffer1 == $past(compare_reg1) && compare_buffer0 == $past(compare_reg0))
    else $error("batch transfer missed");

  anytime_a: assert property (count_enable_bit && wr_hit(bus, OFF_CCR0)
    && !is_batch(mode_select_field) |=> compare_buffer0 == $past(bus.wdata))
    else $error("anytime write not copied");

  idle_buf_a: assert property (!count_enable_bit
    |=> compare_buffer0 == ZERO16 && compare_buffer1 == ZERO16 && !batch_pending)
    else $error("buffers not cleared when idle");

  out1_toggle_a: assert property (tick && !first_tick && match1
    && mode_select_field == MD_INTERVAL |=> timer_output1_pin != $past(timer_output1_pin)
      && compare1_irq)
    else $error("output1 did not toggle");
endmodule // timer16_interval_core

// >>> tb/tic_pin_model.sv
// External event source for the timer core input pin.
// Assumes the bench raises run to start a steady edge train on mclk.
`timescale 1ns/100ps
module tic_pin_model
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [3:0] half,
  output logic pin
);
  logic [3:0] cnt;
  // Square wave, half period of half cycles, idle low between runs
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n || !run)
    begin
      cnt <= 4'h0;
      pin <= 1'b0;
    end
    else if (cnt == half - 4'h1)
    begin
      cnt <= 4'h0;
      pin <= ~pin;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule // tic_pin_model

// >>> tb/test_timer16_interval_core.sv
// Self-checking bench for the timer core: reads queued, periods measured.
// Assumes the register port and pin model drive the only inputs.
`timescale 1ns/100ps
module test_timer16_interval_core;
  import tic_pkg::*;
  logic mclk;
  logic arst_n;
  tic_bus_t bus;
  logic [15:0] rdata;
  logic pin;
  logic out0;
  logic out1;
  logic irq0;
  logic irq1;
  logic irqov;
  logic run;
  logic rd_d;
  logic f;
  logic [15:0] ccr0;
  logic [15:0] expq[$];
  int bad_count;
  int cmp_count;
  int pre;
  int n;
  int n0;
  int n1;
  int nov;
  int nt;

  timer16_interval_core timer16_interval_core_i (.mclk(mclk), .arst_n(arst_n), .bus(bus),
    .rdata(rdata), .ext_input0_pin(pin), .timer_output0_pin(out0),
    .timer_output1_pin(out1), .compare0_irq(irq0), .compare1_irq(irq1),
    .overflow_irq(irqov));
  tic_pin_model tic_pin_model_i (.mclk(mclk), .arst_n(arst_n), .run(run), .half(4'h4),
    .pin(pin));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  ////////////////////////////////////////
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_n(input int e, input int g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    expq.push_back(e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
  endtask

  // Cycles between two compare0 pulses, and whether output0 flipped
  task automatic gap();
    logic o;
    int i;
    n = 0;
    i = 0;
    @(negedge mclk);
    while (irq0 !== 1'b1 && i < 5000)
    begin
      @(negedge mclk);
      i++;
    end
    o = out0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (irq0 !== 1'b1 && n < 5000);
    f = (out0 !== o);
  endtask

  // Pulse counts over a window, plus output1 toggles
  task automatic tally(input int cyc);
    logic p;
    n0 = 0;
    n1 = 0;
    nov = 0;
    nt = 0;
    p = out1;
    repeat (cyc)
    begin
      @(negedge mclk);
      n0 += int'(irq0 === 1'b1);
      n1 += int'(irq1 === 1'b1);
      nov += int'(irqov === 1'b1);
      nt += int'(out1 !== p);
      p = out1;
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////
  // Read results checked one cycle after the strobe, oldest note first
  always @(posedge mclk) rd_d <= bus.rd;
  always @(negedge mclk)
  begin
    if (rd_d === 1'b1 && expq.size() > 0)
      chk16(expq.pop_front(), rdata);
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    test_done();
  end

  initial
  begin
    bus = '0;
    arst_n = 1'b0;
    run = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(38));
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFF_CNT, ZERO16);
    $display("test idle done");
    pre = $urandom_range(2);
    ccr0 = 16'($urandom_range(9, 2));
    wr(OFF_CCR0, ccr0);
    wr(OFF_CTL0, 16'h0080 | 16'(pre));
    gap();
    chk_n((int'(ccr0) + 1) << pre, n);
    chk_n(1, int'(f));
    wr(OFF_CTL1, 16'h0040);
    gap();
    chk_n((int'(ccr0) + 1) << pre, n);
    ccr0 = ccr0 + 16'h0004;
    wr(OFF_CCR0, ccr0);
    gap();
    chk_n((int'(ccr0) + 1) << pre, n);
    wr(OFF_CCR1, 16'h0001);
    gap();
    tally((int'(ccr0) + 1) << (pre + 2));
    chk_n(4, n0);
    chk_n(4, n1);
    chk_n(4, nt);
    wr(OFF_CCR1, ccr0 + 16'h0005);
    gap();
    tally((int'(ccr0) + 1) << (pre + 2));
    chk_n(0, n1);
    chk_n(0, nt);
    wr(OFF_CTL0, 16'h0000);
    rd(OFF_CNT, ZERO16);
    @(negedge mclk);
    chk16(16'h0000, {14'h0, out0, out1});
    $display("test interval done");
    wr(OFF_CCR0, 16'h00ff);
    wr(OFF_CTL0, 16'h0080);
    repeat (10) @(posedge mclk);
    rd(OFF_CNT, 16'h000a);
    @(negedge mclk);
    chk16(16'h0001, {15'h0, out0});
    wr(OFF_CTL0, 16'h0000);
    wr(OFF_CCR0, ZERO16);
    wr(OFF_CTL0, 16'h0080);
    repeat (5) @(negedge mclk);
    tally(10);
    chk_n(10, n0);
    rd(OFF_CNT, ZERO16);
    wr(OFF_CTL0, 16'h0000);
    $display("test live count done");
    wr(OFF_CTL1, 16'h0004);
    wr(OFF_CCR0, 16'h0003);
    wr(OFF_CCR1, 16'h0000);
    wr(OFF_CTL0, 16'h0080);
    gap();
    chk_n(4, n);
    wr(OFF_CCR0, 16'h0007);
    gap();
    chk_n(4, n);
    wr(OFF_CCR1, 16'h0000);
    gap();
    chk_n(8, n);
    wr(OFF_CTL0, 16'h0000);
    $display("test batch done");
    wr(OFF_IOC1, 16'h0000);
    wr(OFF_IOC2, 16'h0001);
    wr(OFF_CTL1, 16'h0001);
    wr(OFF_CCR0, 16'h0002);
    wr(OFF_CCR1, 16'h0000);
    wr(OFF_CTL0, 16'h0080);
    run <= 1'b1;
    gap();
    gap();
    chk_n(24, n);
    wr(OFF_CTL0, 16'h0000);
    run <= 1'b0;
    wr(OFF_IOC2, 16'h0000);
    $display("test event done");
    wr(OFF_CTL1, 16'h0005);
    wr(OFF_OPT0, 16'h0002);
    wr(OFF_CTL0, 16'h0080);
    tally(65600);
    chk_n(1, nov);
    rd(OFF_OPT0, 16'h0003);
    wr(OFF_OPT0, 16'h0002);
    rd(OFF_OPT0, 16'h0002);
    wr(OFF_CTL0, 16'h0000);
    repeat (3) @(posedge mclk);
    $display("test overflow done");
    test_done();
  end
endmodule // test_timer16_interval_core
